/* File: apc_top.sv */
/*
  aux pin configuration block: management bus slave with pin configuration
  registers, three configurable aux pins, and the double-rate host data
  capture with link clock presence detection.
  assumes external pullups on the bus wires, the bus select driven by the host,
  and lock and loss-of-signal status coming from logic on clk.
*/
// Functional notes
// R1: upper nibble picks function, per-pin sets
// R2: pin 2 drives host level or serializer clock
// R3: pin 2 input level readable over bus
// R4: bits 3:2 choose no bias, pulldown, pullup
// R5: bit 1 enables input buffer
// R6: bit 0 drives pin, else high impedance
// R7: pin 0 code 0001 0001 shows lock
// R8: five data bits taken on both edges
// R9: bus answers only while select is active
// R10: outputs follow source; reads give synchronised level
`timescale 1ns/1ps
module apc_top
  import apc_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDR = DEV_ADDR
) (
  // system clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // management bus, open drain data
  input wire logic mgmt_scl,
  input wire logic mgmt_sda_in,
  output logic mgmt_sda_out,
  output logic mgmt_sda_oe_b,
  input wire logic mgmt_bus_select,
  // aux pins
  input wire logic [2:0] aux_in,
  output logic [2:0] aux_out,
  output logic [2:0] aux_oe_b,
  output logic [2:0] aux_pull_up,
  output logic [2:0] aux_pull_down,
  output logic [2:0] aux_in_buf_en,
  // internal status
  input wire logic lock_status,
  input wire logic [4:0] los_status,
  // host data link
  input wire logic host_ddr_clock,
  input wire logic [4:0] host_data,
  output apc_word_t host_word,
  output logic host_word_valid
);

  logic scl_s;
  logic sda_s;
  logic cs_s;
  logic [2:0] aux_in_s;
  logic scl_q;
  logic sda_q;
  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic scl_fall;
  apc_state_t state;
  apc_state_t next_state;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [1:0] phase;
  logic [1:0] next_phase;
  logic rw;
  logic next_rw;
  logic acked;
  logic next_acked;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic sda_oe_b;
  logic next_sda_oe_b;
  logic [7:0] rd_byte;
  apc_cfg_t cfg [3];
  apc_cfg_t next_cfg [3];
  logic [2:0] out_lvl;
  logic [2:0] next_out_lvl;
  logic [2:0] in_lvl;
  logic por_active;
  logic link_toggle;
  logic toggle_q;
  logic clk_det;
  logic next_clk_det;
  logic [15:0] loss_cnt;
  logic [15:0] next_loss_cnt;
  logic [2:0] src;
  logic [2:0] is_out;
  logic [2:0] next_aux_out;
  logic [2:0] next_aux_oe_b;
  logic [2:0] next_pull_up;
  logic [2:0] next_pull_down;
  logic [2:0] next_in_buf_en;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  apc_sync #(.WIDTH(6)) u_pin_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in({mgmt_scl, mgmt_sda_in, mgmt_bus_select, aux_in}),
    .sync_out({scl_s, sda_s, cs_s, aux_in_s})
  );

  // host data capture on the link clock
  apc_ddr_rx u_ddr_rx (
    .clk(clk),
    .rst_b(rst_b),
    .host_ddr_clock(host_ddr_clock),
    .host_data(host_data),
    .word_out(host_word),
    .word_valid(host_word_valid),
    .link_toggle(link_toggle)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus conditions from synchronised wires
  assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_seen = scl_s & scl_q & ~sda_q & sda_s;
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;

  // input level as seen through the buffer
  assign in_lvl = aux_in_s & {cfg[2].in_en, cfg[1].in_en, cfg[0].in_en}; // R5 R10

  // register read mux
  always_comb begin
    case (ptr)
      REG_CFG0: rd_byte = cfg[0];
      REG_CFG1: rd_byte = cfg[1];
      REG_CFG2: rd_byte = cfg[2];
      REG_OUT_LVL: rd_byte = {5'h00, out_lvl};
      REG_IN_LVL: rd_byte = {5'h00, in_lvl}; // R3 R10
      default: rd_byte = RD_UNMAPPED;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // management bus slave and register writes
  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shift = shift;
    next_phase = phase;
    next_rw = rw;
    next_acked = acked;
    next_ptr = ptr;
    next_sda_oe_b = sda_oe_b;
    next_cfg = cfg;
    next_out_lvl = out_lvl;
    if (!cs_s || stop_seen) begin
      next_state = ST_IDLE; // R9
      next_sda_oe_b = 1'b1;
    end else if (start_seen) begin
      next_state = ST_RX;
      next_bitcnt = 4'h0;
      next_phase = 2'h0;
      next_sda_oe_b = 1'b1;
    end else begin
      case (state)
        ST_RX: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == BITS_PER_BYTE) begin
            next_bitcnt = 4'h0;
            case (phase)
              2'h0: begin
                if (shift[7:1] == DEVICE_ADDR) begin
                  next_rw = shift[0];
                  next_phase = 2'h1;
                  next_state = ST_ACK;
                  next_sda_oe_b = 1'b0;
                end else begin
                  next_state = ST_IDLE;
                end
              end
              2'h1: begin
                next_ptr = shift;
                next_phase = 2'h2;
                next_state = ST_ACK;
                next_sda_oe_b = 1'b0;
              end
              default: begin
                case (ptr)
                  REG_CFG0: next_cfg[0] = shift; // R1 R7
                  REG_CFG1: next_cfg[1] = shift;
                  REG_CFG2: next_cfg[2] = shift;
                  REG_OUT_LVL: next_out_lvl = shift[2:0]; // R2
                  default: next_out_lvl = out_lvl;
                endcase
                next_ptr = ptr + 8'h01;
                next_state = ST_ACK;
                next_sda_oe_b = 1'b0;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (rw) begin
              next_sda_oe_b = rd_byte[7];
              next_shift = {rd_byte[6:0], 1'b0};
              next_bitcnt = 4'h1;
              next_ptr = ptr + 8'h01;
              next_state = ST_TX;
            end else begin
              next_sda_oe_b = 1'b1;
              next_state = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bitcnt == BITS_PER_BYTE) begin
              next_sda_oe_b = 1'b1;
              next_state = ST_MACK;
            end else begin
              next_sda_oe_b = shift[7];
              next_shift = {shift[6:0], 1'b0};
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            next_acked = ~sda_s;
          end else if (scl_fall) begin
            if (acked) begin
              next_sda_oe_b = rd_byte[7];
              next_shift = {rd_byte[6:0], 1'b0};
              next_bitcnt = 4'h1;
              next_ptr = ptr + 8'h01;
              next_state = ST_TX;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_sda_oe_b = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shift <= 8'h00;
      phase <= 2'h0;
      rw <= 1'b0;
      acked <= 1'b0;
      ptr <= 8'h00;
      sda_oe_b <= 1'b1;
      mgmt_sda_out <= 1'b0;
      mgmt_sda_oe_b <= 1'b1;
      cfg[0] <= CFG_RESET;
      cfg[1] <= CFG_RESET;
      cfg[2] <= CFG_RESET;
      out_lvl <= OUT_LVL_RESET;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      state <= next_state;
      bitcnt <= next_bitcnt;
      shift <= next_shift;
      phase <= next_phase;
      rw <= next_rw;
      acked <= next_acked;
      ptr <= next_ptr;
      sda_oe_b <= next_sda_oe_b;
      mgmt_sda_out <= 1'b0; // open drain pulls low only
      mgmt_sda_oe_b <= next_sda_oe_b;
      cfg <= next_cfg;
      out_lvl <= next_out_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link clock presence and power-on indicator
  always_comb begin
    next_clk_det = clk_det;
    next_loss_cnt = loss_cnt;
    if (link_toggle != toggle_q) begin
      next_loss_cnt = 16'h0000;
      next_clk_det = 1'b1;
    end else if (loss_cnt == 16'(LOSS_CYCLES)) begin
      next_clk_det = 1'b0;
    end else begin
      next_loss_cnt = loss_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      toggle_q <= 1'b0;
      clk_det <= 1'b0;
      loss_cnt <= 16'h0000;
      por_active <= 1'b1;
    end else begin
      toggle_q <= link_toggle;
      clk_det <= next_clk_det;
      loss_cnt <= next_loss_cnt;
      por_active <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pin function select, bias, buffer and drive
  always_comb begin
    src = 3'h0;
    is_out = 3'h0;
    case (cfg[0].func) // R1
      F0_OUT: {is_out[0], src[0]} = {1'b1, out_lvl[0]};
      F0_LOCK: {is_out[0], src[0]} = {1'b1, lock_status}; // R7
      F0_CLK: {is_out[0], src[0]} = {1'b1, link_toggle};
      F0_DET: {is_out[0], src[0]} = {1'b1, clk_det};
      F0_POR: {is_out[0], src[0]} = {1'b1, por_active};
      default: {is_out[0], src[0]} = 2'h0;
    endcase
    case (cfg[1].func) // R1
      F1_POR: {is_out[1], src[1]} = {1'b1, por_active};
      F1_OUT: {is_out[1], src[1]} = {1'b1, out_lvl[1]};
      F1_IN: {is_out[1], src[1]} = 2'h0;
      default: begin
        if (cfg[1].func >= F1_LOS0 && cfg[1].func <= F1_LOS4) begin
          is_out[1] = 1'b1;
          src[1] = los_status[3'(cfg[1].func - F1_LOS0)];
        end
      end
    endcase
    case (cfg[2].func) // R1
      F2_OUT: {is_out[2], src[2]} = {1'b1, out_lvl[2]}; // R2
      F2_CLK: {is_out[2], src[2]} = {1'b1, link_toggle}; // R2
      default: {is_out[2], src[2]} = 2'h0; // R3
    endcase
    for (int i = 0; i < 3; i++) begin
      next_aux_out[i] = src[i] & cfg[i].drive; // R10
      next_aux_oe_b[i] = ~(is_out[i] & cfg[i].drive); // R6
      next_pull_up[i] = (cfg[i].bias == BIAS_UP); // R4
      next_pull_down[i] = (cfg[i].bias == BIAS_DOWN); // R4
      next_in_buf_en[i] = cfg[i].in_en; // R5
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_out <= 3'h0;
      aux_oe_b <= 3'h7;
      aux_pull_up <= 3'h0;
      aux_pull_down <= 3'h0;
      aux_in_buf_en <= 3'h0;
    end else begin
      aux_out <= next_aux_out;
      aux_oe_b <= next_aux_oe_b;
      aux_pull_up <= next_pull_up;
      aux_pull_down <= next_pull_down;
      aux_in_buf_en <= next_in_buf_en;
    end
  end

endmodule

/* File: apc_pkg.sv */
/*
  constants, field layouts and types shared by the aux pin configuration block.
  assumes a 25 mhz system clock and an 8-bit management register space.
*/
package apc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets on the management bus
  localparam logic [7:0] REG_CFG0 = 8'h10;
  localparam logic [7:0] REG_CFG1 = 8'h11;
  localparam logic [7:0] REG_CFG2 = 8'h12;
  localparam logic [7:0] REG_OUT_LVL = 8'h13;
  localparam logic [7:0] REG_IN_LVL = 8'h14;

  // reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [2:0] OUT_LVL_RESET = 3'h0;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // seven-bit management bus device address
  localparam logic [6:0] DEV_ADDR = 7'h57;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // pin configuration field layout: function, bias, input buffer, drive
  typedef struct packed {
    logic [3:0] func;
    logic [1:0] bias;
    logic in_en;
    logic drive;
  } apc_cfg_t;

  // bias codes
  localparam logic [1:0] BIAS_NONE = 2'h0;
  localparam logic [1:0] BIAS_DOWN = 2'h1;
  localparam logic [1:0] BIAS_UP = 2'h2;

  // functions of pin 0
  localparam logic [3:0] F0_OUT = 4'h0;
  localparam logic [3:0] F0_LOCK = 4'h1;
  localparam logic [3:0] F0_IN = 4'h2;
  localparam logic [3:0] F0_CLK = 4'h3;
  localparam logic [3:0] F0_DET = 4'h4;
  localparam logic [3:0] F0_POR = 4'h5;
  // functions of pin 1; loss of signal for data bit k is F1_LOS0 + k
  localparam logic [3:0] F1_POR = 4'h0;
  localparam logic [3:0] F1_OUT = 4'h1;
  localparam logic [3:0] F1_IN = 4'h2;
  localparam logic [3:0] F1_LOS0 = 4'h3;
  localparam logic [3:0] F1_LOS4 = 4'h7;
  // functions of pin 2
  localparam logic [3:0] F2_OUT = 4'h0;
  localparam logic [3:0] F2_IN = 4'h1;
  localparam logic [3:0] F2_CLK = 4'h2;

  ////////////////////////////////////////////////////////////////////////////
  // timing: link clock counts as lost after this long without an edge
  localparam int CLK_PERIOD_NS = 40;
  localparam int LOSS_NS = 2000;
  localparam int LOSS_CYCLES = LOSS_NS / CLK_PERIOD_NS;

  // one double-rate word: rising-edge half first, falling-edge half second
  typedef struct packed {
    logic [4:0] rise;
    logic [4:0] fall;
  } apc_word_t;

  // management bus slave states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK
  } apc_state_t;

endpackage

/* File: apc_sync.sv */
/*
  two flip-flop level synchroniser, one per bit.
  assumes each bit is a level that stays put for several destination clocks.
*/
`timescale 1ns/1ps
module apc_sync #(
  parameter int WIDTH = 1
) (
  // destination clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1) begin : g_chk
    $error("apc_sync needs WIDTH of at least 1");
  end

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

/* File: apc_ddr_rx.sv */
/*
  double-rate capture of the host data bus on the forwarded clock, with a
  req/ack handshake that carries whole words into the system clock domain.
  assumes the forwarded clock runs while words are sent; words arriving while
  a handshake is open are dropped, there is no buffer.
*/
`timescale 1ns/1ps
module apc_ddr_rx
  import apc_pkg::*;
(
  // system clock domain
  input wire logic clk,
  input wire logic rst_b,
  // link clock domain
  input wire logic host_ddr_clock,
  input wire logic [4:0] host_data,
  // word handed to the system domain
  output apc_word_t word_out,
  output logic word_valid,
  // link activity toggle, synchronised
  output logic link_toggle
);

  logic [4:0] rise_q;
  logic [4:0] fall_q;
  apc_word_t hold;
  apc_word_t next_hold;
  logic req;
  logic next_req;
  logic tog;
  logic ack_s;
  logic req_s;
  logic ack;
  logic next_ack;
  apc_word_t next_word_out;
  logic next_word_valid;

  ////////////////////////////////////////////////////////////////////////////
  // falling-edge half of each pair
  always_ff @(negedge host_ddr_clock or negedge rst_b) begin
    if (!rst_b) begin
      fall_q <= '0;
    end else begin
      fall_q <= host_data; // R8
    end
  end

  // take a new pair only when the previous handshake has closed
  always_comb begin
    next_hold = hold;
    next_req = req;
    if (req == ack_s) begin
      next_hold = '{rise: rise_q, fall: fall_q}; // R8
      next_req = ~req;
    end
  end

  // rising-edge half, held word, request and activity toggle
  always_ff @(posedge host_ddr_clock or negedge rst_b) begin
    if (!rst_b) begin
      rise_q <= '0;
      hold <= '0;
      req <= 1'b0;
      tog <= 1'b0;
    end else begin
      rise_q <= host_data; // R8
      hold <= next_hold;
      req <= next_req;
      tog <= ~tog;
    end
  end

  apc_sync #(.WIDTH(1)) u_ack_sync (
    .clk(host_ddr_clock),
    .rst_b(rst_b),
    .async_in(ack),
    .sync_out(ack_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // system side: the held word is stable while req and ack differ
  apc_sync #(.WIDTH(2)) u_req_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in({req, tog}),
    .sync_out({req_s, link_toggle})
  );

  always_comb begin
    next_ack = ack;
    next_word_out = word_out;
    next_word_valid = 1'b0;
    if (req_s != ack) begin
      next_word_out = hold;
      next_word_valid = 1'b1;
      next_ack = req_s;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'b0;
      word_out <= '0;
      word_valid <= 1'b0;
    end else begin
      ack <= next_ack;
      word_out <= next_word_out;
      word_valid <= next_word_valid;
    end
  end

endmodule

/* File: apc_chk.sv */
/*
  port checker for apc_top: bus release, pin quiet levels, link words.
  assumes it is bound into apc_top and sees that module's ports only.
*/
`timescale 1ns/1ps
module apc_chk
  import apc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // management bus
  input wire logic mgmt_scl,
  input wire logic mgmt_sda_out,
  input wire logic mgmt_sda_oe_b,
  input wire logic mgmt_bus_select,
  // aux pins
  input wire logic [2:0] aux_out,
  input wire logic [2:0] aux_oe_b,
  input wire logic [2:0] aux_pull_up,
  input wire logic [2:0] aux_pull_down,
  // host data link
  input wire logic host_ddr_clock,
  input wire apc_word_t host_word,
  input wire logic host_word_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////
  // bus: released while deselected, open drain, no edge while scl high
  sda_release_a: assert property (!mgmt_bus_select [*5] |-> mgmt_sda_oe_b)
    else $error("sda pulled while deselected");
  sda_open_a: assert property (mgmt_sda_out == 1'b0)
    else $error("sda driven high");
  sda_quiet_a: assert property ($changed(mgmt_sda_oe_b) && mgmt_bus_select |-> !mgmt_scl)
    else $error("sda moved while scl high");
  // pins: one bias at most, undriven pins stay low
  bias_excl_a: assert property ((aux_pull_up & aux_pull_down) == 3'b000)
    else $error("pullup and pulldown together");
  pin_quiet_a: assert property ((aux_out & aux_oe_b) == 3'b000)
    else $error("level on undriven pin");
  // link: one-cycle pulse, word held between pulses, nothing without clock
  word_pulse_a: assert property ($rose(host_word_valid) |=> !host_word_valid [*3])
    else $error("word valid too long");
  word_hold_a: assert property ($changed(host_word) |-> host_word_valid)
    else $error("word changed without valid");
  link_idle_a: assert property ($stable(host_ddr_clock) [*8] |-> !host_word_valid)
    else $error("word without link clock");
endmodule
bind apc_top apc_chk chk_i (.clk, .rst_b, .mgmt_scl, .mgmt_sda_out, .mgmt_sda_oe_b, .mgmt_bus_select,
  .aux_out, .aux_oe_b, .aux_pull_up, .aux_pull_down, .host_ddr_clock, .host_word, .host_word_valid);

/* File: apc_host.sv */
/*
  host model: management bus master and double-rate link sender.
  assumes the bench drives the bus select and judges the results.
*/
`timescale 1ns/1ps
module apc_host
  import apc_pkg::*;
(
  // system clock
  input wire logic clk,
  // management bus wires
  output logic mgmt_scl,
  output logic mgmt_sda_in,
  input wire logic mgmt_sda_out,
  input wire logic mgmt_sda_oe_b,
  // double-rate link
  output logic host_ddr_clock,
  output logic [4:0] host_data
);
  logic sda_low;
  // pulled-up data wire: low if either side pulls
  assign mgmt_sda_in = !sda_low & (mgmt_sda_oe_b | mgmt_sda_out);
  initial begin
    mgmt_scl = 1'b1;
    sda_low = 1'b0;
    host_ddr_clock = 1'b0;
    host_data = 5'h00;
  end
  ////////////////////////////////////////////////////////////
  // half a bus bit, slow enough for the synchronisers
  task automatic half();
    repeat (10) @(posedge clk);
  endtask
  // one bit; data moves only while scl is low
  task automatic bitx(input logic b, output logic r);
    @(posedge clk);
    sda_low <= !b;
    half();
    mgmt_scl <= 1'b1;
    half();
    r = mgmt_sda_in;
    mgmt_scl <= 1'b0;
  endtask
  // byte msb first, ninth bit released; ack is low ninth bit
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(1'b1, r);
    ack = !r;
  endtask
  // start, also repeated start from scl low
  task automatic start();
    @(posedge clk);
    sda_low <= 1'b0;
    half();
    mgmt_scl <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    mgmt_scl <= 1'b0;
  endtask
  task automatic stop();
    @(posedge clk);
    sda_low <= 1'b1;
    half();
    mgmt_scl <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask
  // one register write; ok when all bytes acked
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k1, k2, k3;
    start();
    xfer({DEV_ADDR, 1'b0}, q, k1);
    xfer(a, q, k2);
    xfer(d, q, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  // one register read, closed by a nack
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k1, k2, k3, k4;
    start();
    xfer({DEV_ADDR, 1'b0}, q, k1);
    xfer(a, q, k2);
    start();
    xfer({DEV_ADDR, 1'b1}, q, k3);
    xfer(8'hff, d, k4);
    stop();
    ok = k1 & k2 & k3;
  endtask
  // one word on six link cycles; clock still and data inverted afterwards
  task automatic frame(input apc_word_t w);
    #13;
    repeat (6) begin
      host_data <= w.rise;
      #20 host_ddr_clock <= 1'b1;
      #20 host_data <= w.fall;
      #20 host_ddr_clock <= 1'b0;
      #20;
    end
    host_data <= ~w.fall;
  endtask
endmodule

/* File: testbench.sv */
/*
  self-checking bench for apc_top driven through the host model.
  assumes the design answers at the package's default device address.
*/
`timescale 1ns/1ps
module testbench
  import apc_pkg::*;
;
  logic clk, rst_b, mgmt_scl, mgmt_sda_in, mgmt_sda_out, mgmt_sda_oe_b, mgmt_bus_select;
  logic [2:0] aux_in, aux_out, aux_oe_b, aux_pull_up, aux_pull_down, aux_in_buf_en;
  logic lock_status, host_ddr_clock, host_word_valid, ok;
  logic [4:0] los_status, host_data;
  logic [7:0] v;
  apc_word_t host_word;
  int num_errors, total_checks, k;
  apc_top uut (.clk, .rst_b, .mgmt_scl, .mgmt_sda_in, .mgmt_sda_out, .mgmt_sda_oe_b, .mgmt_bus_select,
    .aux_in, .aux_out, .aux_oe_b, .aux_pull_up, .aux_pull_down, .aux_in_buf_en, .lock_status,
    .los_status, .host_ddr_clock, .host_data, .host_word, .host_word_valid);
  apc_host host (.clk, .mgmt_scl, .mgmt_sda_in, .mgmt_sda_out, .mgmt_sda_oe_b, .host_ddr_clock, .host_data);
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////
  // compare, count, report
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrc(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d, ok);
    chk("ack", 16'h0001, 16'(ok));
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, v, ok);
    chk("ack", 16'h0001, 16'(ok));
    chk("reg", 16'(e), 16'(v));
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // reset levels of pins and configuration
  task automatic t_reset();
    chk("oe_b", 16'h0007, 16'(aux_oe_b));
    chk("bias", 16'h0000, 16'({aux_pull_up, aux_pull_down, aux_in_buf_en}));
    for (k = 0; k < 3; k++) begin
      rdc(REG_CFG0 + 8'(k), CFG_RESET);
    end
  endtask
  // pin 0 follows lock under code 0001 0001
  task automatic t_lock();
    wrc(REG_CFG0, 8'h11);
    for (k = 1; k >= 0; k--) begin
      lock_status <= k[0];
      repeat (3) @(posedge clk);
      chk("lock pin", 16'(k), 16'({aux_oe_b[0], aux_out[0]}));
    end
  endtask
  // each bias code on pin 1 used as input
  task automatic t_bias();
    for (k = 0; k < 4; k++) begin
      wrc(REG_CFG1, {F1_IN, k[1:0], 2'b10});
      v = {4'h0, k == 2, k == 1, 2'b11};
      chk("pulls", 16'(v), 16'({aux_pull_up[1], aux_pull_down[1], aux_in_buf_en[1], aux_oe_b[1]}));
      rdc(REG_CFG1, {F1_IN, k[1:0], 2'b10});
    end
  endtask
  // pin 2 as host level, as input, as serializer clock
  task automatic t_pin2();
    wrc(REG_OUT_LVL, 8'h04);
    wrc(REG_CFG2, {F2_OUT, BIAS_NONE, 2'b01});
    chk("pin2 out", 16'h0001, 16'({aux_oe_b[2], aux_out[2]}));
    wrc(REG_CFG2, {F2_IN, BIAS_UP, 2'b10});
    for (k = 1; k >= 0; k--) begin
      aux_in <= {k[0], 2'b00};
      repeat (4) @(posedge clk);
      rdc(REG_IN_LVL, {5'h00, k[0], 2'b00});
    end
    wrc(REG_CFG2, {F2_CLK, BIAS_NONE, 2'b01});
    v = 8'h00;
    fork
      host.frame('0);
      repeat (12) @(posedge clk) v = v + 8'(aux_out[2]);
    join
    chk("pin2 clk", 16'h0001, 16'(v > 0 && v < 12));
  endtask
  // deselected device ignores a write; unmapped place reads zero
  task automatic t_desel();
    @(posedge clk);
    mgmt_bus_select <= 1'b0;
    host.wr(REG_CFG0, 8'h00, ok);
    chk("nack", 16'h0000, 16'(ok));
    mgmt_bus_select <= 1'b1;
    chk("cfg kept", 16'h0000, 16'(aux_oe_b[0]));
    wrc(8'h20, 8'h5a);
    rdc(8'h20, RD_UNMAPPED);
  endtask
  // link words in both halves, presence shown and lost on pin 0
  task automatic t_link();
    apc_word_t w;
    wrc(REG_CFG0, {F0_DET, BIAS_NONE, 2'b01});
    for (k = 0; k < 2; k++) begin
      w = k ? {5'h0e, 5'h11} : {5'h15, 5'h0a};
      host.frame(w);
      repeat (4) @(posedge clk);
      chk("word", 16'(w), 16'(host_word));
      chk("link on", 16'h0001, 16'({aux_oe_b[0], aux_out[0]}));
    end
    repeat (60) @(posedge clk);
    chk("link off", 16'h0000, 16'({aux_oe_b[0], aux_out[0]}));
    chk("valid", 16'h0000, 16'(host_word_valid));
  endtask
  // pin 1 as host level, then showing the loss bit its code picks
  task automatic t_los();
    wrc(REG_CFG1, {F1_OUT, BIAS_NONE, 2'b01});
    chk("pin1 out", 16'h0000, 16'({aux_oe_b[1], aux_out[1]}));
    wrc(REG_CFG1, {F1_LOS0 + 4'h2, BIAS_NONE, 2'b01});
    for (k = 1; k >= 0; k--) begin
      los_status <= k ? 5'h04 : 5'h1b;
      repeat (3) @(posedge clk);
      chk("los pin", 16'(k), 16'({aux_oe_b[1], aux_out[1]}));
    end
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence and hang limit
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    aux_in = 3'h0;
    lock_status = 1'b0;
    los_status = 5'h00;
    mgmt_bus_select = 1'b1;
    num_errors = 0;
    total_checks = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_lock();
    t_bias();
    t_pin2();
    t_desel();
    t_link();
    t_los();
    give_verdict();
  end
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule
